//--- pbr_map.svh
`ifndef PBR_MAP_SVH
`define PBR_MAP_SVH

// Station address field and legal range of an extra address
`define PBR_ADDR_W        10
`define PBR_ADDR_OFF      10'h000
`define PBR_ADDR_MAX      10'h3E7

// Internal data items
`define PBR_ITEM_W        20
`define PBR_SEL_W         4
`define PBR_ITEM_DEPTH    16
`define PBR_PRI_LVL_ITEM  4'h0
`define PBR_PRI_TMP_ITEM  4'h1

// Level field: 0 to 80 in 0.001 steps, temperature: +-799.9 in 0.1 steps
`define PBR_LVL_W         17
`define PBR_LVL_MAX       20'h13880
`define PBR_TMP_W         14
`define PBR_TMP_MAX       20'h01F3F

// Response delay unit of 1 us at the 4 ns clock
`define PBR_CLK_NS        4
`define PBR_TICK_NS       1000
`define PBR_TICK_CYC      ((`PBR_TICK_NS + `PBR_CLK_NS - 1) / `PBR_CLK_NS)
`define PBR_TICK_W        8
`define PBR_DLY_W         16
`define PBR_CNT_W         16

`endif

//--- pbr_pkg.sv
package pbr_pkg;

  // Operator bus command
  typedef enum logic [1:0] {
    PBR_CMD_ISOLATE = 2'h0,
    PBR_CMD_CONNECT = 2'h1,
    PBR_CMD_TEST    = 2'h2
  } pbr_cmd_t;

  // Address slot that a poll matched
  typedef enum logic [1:0] {
    PBR_SLOT_PRIMARY = 2'h0,
    PBR_SLOT_SECOND  = 2'h1,
    PBR_SLOT_THIRD   = 2'h2
  } pbr_slot_t;

  typedef enum logic [3:0] {
    PBR_LINK_CONN = 4'h1,
    PBR_LINK_ISO  = 4'h2,
    PBR_LINK_TDET = 4'h4,
    PBR_LINK_TRUN = 4'h8
  } pbr_link_t;

  typedef enum logic [4:0] {
    PBR_RSP_IDLE = 5'h01,
    PBR_RSP_WAIT = 5'h02,
    PBR_RSP_RDL  = 5'h04,
    PBR_RSP_RDT  = 5'h08,
    PBR_RSP_SEND = 5'h10
  } pbr_rsp_t;

endpackage

//--- pbr_item_mem.sv
`include "pbr_map.svh"

module pbr_item_mem #(
  parameter int W     = `PBR_ITEM_W,
  parameter int DEPTH = `PBR_ITEM_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic          clk_i,
  // Write side
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i,
  // Read side
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [W-1:0]  rd_data_o
);

  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule

//--- pbr_responder.sv
`include "pbr_map.svh"

module pbr_responder #(
  parameter int DEPTH    = `PBR_ITEM_DEPTH,
  parameter int TICK_CYC = `PBR_TICK_CYC
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  // Operator bus command
  input  wire logic                   cmd_valid_i,
  input  wire pbr_pkg::pbr_cmd_t      cmd_code_i,
  // Transceiver self-check
  output logic                        xcvr_test_start_o,
  input  wire logic                   xcvr_test_done_i,
  input  wire logic                   xcvr_test_pass_i,
  // Bus attachment and state
  output logic                        bus_attach_o,
  output logic                        relay_close_o,
  output logic                        bus_link_state_o,
  output logic                        test_busy_o,
  // Configuration
  input  wire logic [`PBR_ADDR_W-1:0] primary_address_i,
  input  wire logic [`PBR_ADDR_W-1:0] second_station_address_i,
  input  wire logic [`PBR_ADDR_W-1:0] third_station_address_i,
  input  wire logic [`PBR_SEL_W-1:0]  second_level_selector_i,
  input  wire logic [`PBR_SEL_W-1:0]  second_temp_selector_i,
  input  wire logic [`PBR_SEL_W-1:0]  third_level_selector_i,
  input  wire logic [`PBR_SEL_W-1:0]  third_temp_selector_i,
  input  wire logic [`PBR_DLY_W-1:0]  resp_delay_i,
  // Internal data item writes
  input  wire logic                   item_wr_i,
  input  wire logic [`PBR_SEL_W-1:0]  item_wr_addr_i,
  input  wire logic [`PBR_ITEM_W-1:0] item_wr_data_i,
  // Decoded polls from the frame receiver
  input  wire logic                   poll_end_i,
  input  wire logic [`PBR_ADDR_W-1:0] poll_address_i,
  input  wire logic                   com_error_i,
  // Reply toward the frame transmitter
  output logic                        reply_valid_o,
  output logic [`PBR_ADDR_W-1:0]      reply_address_o,
  output pbr_pkg::pbr_slot_t          reply_slot_o,
  output logic [`PBR_LVL_W-1:0]       reply_level_o,
  output logic [`PBR_TMP_W-1:0]       reply_temp_o,
  // Readable status
  output logic [`PBR_CNT_W-1:0]       poll_count_o,
  output logic [`PBR_CNT_W-1:0]       error_count_o,
  output logic [`PBR_ADDR_W-1:0]      last_poll_address_o,
  output logic [2:0]                  polled_slot_mask_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_active(input logic [`PBR_ADDR_W-1:0] a);
    return (a != `PBR_ADDR_OFF) && (a <= `PBR_ADDR_MAX);
  endfunction

  function automatic logic [`PBR_SEL_W-1:0] pick_sel(
    input pbr_pkg::pbr_slot_t        s,
    input logic [`PBR_SEL_W-1:0]     pri,
    input logic [`PBR_SEL_W-1:0]     sec,
    input logic [`PBR_SEL_W-1:0]     thr
  );
    case (s)
      pbr_pkg::PBR_SLOT_SECOND: return sec;
      pbr_pkg::PBR_SLOT_THIRD:  return thr;
      default:                  return pri;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus link state

  pbr_pkg::pbr_link_t link_q;
  pbr_pkg::pbr_link_t link_d;
  logic               link_shows_conn_q;

  always_comb begin
    link_d = link_q;
    case (link_q)
      pbr_pkg::PBR_LINK_CONN: begin
        if (cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_ISOLATE) begin
          link_d = pbr_pkg::PBR_LINK_ISO;
        end else if (cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_TEST) begin
          link_d = pbr_pkg::PBR_LINK_TDET;
        end
      end
      pbr_pkg::PBR_LINK_ISO: begin
        if (cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_CONNECT) begin
          link_d = pbr_pkg::PBR_LINK_CONN;
        end else if (cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_TEST) begin
          link_d = pbr_pkg::PBR_LINK_TDET;
        end
      end
      pbr_pkg::PBR_LINK_TDET: begin
        link_d = pbr_pkg::PBR_LINK_TRUN;
      end
      pbr_pkg::PBR_LINK_TRUN: begin
        if (xcvr_test_done_i) begin
          link_d = xcvr_test_pass_i ? pbr_pkg::PBR_LINK_CONN
                                    : pbr_pkg::PBR_LINK_ISO;
        end
      end
      default: begin
        link_d = pbr_pkg::PBR_LINK_ISO;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_q <= pbr_pkg::PBR_LINK_CONN;
    end else begin
      link_q <= link_d;
    end
  end

  // Interface and relay follow the state; detached through the whole test
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_attach_o      <= 1'b1;
      relay_close_o     <= 1'b1;
      test_busy_o       <= 1'b0;
      xcvr_test_start_o <= 1'b0;
    end else begin
      bus_attach_o      <= (link_d == pbr_pkg::PBR_LINK_CONN);
      relay_close_o     <= (link_d == pbr_pkg::PBR_LINK_CONN);
      test_busy_o       <= (link_d == pbr_pkg::PBR_LINK_TDET) ||
                           (link_d == pbr_pkg::PBR_LINK_TRUN);
      xcvr_test_start_o <= (link_q == pbr_pkg::PBR_LINK_TDET);
    end
  end

  // Indication keeps its last settled value while a test runs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_shows_conn_q <= 1'b1;
    end else if (link_d == pbr_pkg::PBR_LINK_CONN) begin
      link_shows_conn_q <= 1'b1;
    end else if (link_d == pbr_pkg::PBR_LINK_ISO) begin
      link_shows_conn_q <= 1'b0;
    end
  end

  assign bus_link_state_o = link_shows_conn_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Poll address match

  logic               hit_pri;
  logic               hit_sec;
  logic               hit_thr;
  logic               poll_hit;
  pbr_pkg::pbr_slot_t hit_slot;

  assign hit_pri  = (poll_address_i == primary_address_i);
  assign hit_sec  = addr_active(second_station_address_i) &&
                    (poll_address_i == second_station_address_i);
  assign hit_thr  = addr_active(third_station_address_i) &&
                    (poll_address_i == third_station_address_i);
  assign poll_hit = poll_end_i && bus_attach_o && (hit_pri || hit_sec || hit_thr);
  // Primary, then second, wins if a misconfiguration makes two slots equal
  assign hit_slot = hit_pri ? pbr_pkg::PBR_SLOT_PRIMARY :
                    hit_sec ? pbr_pkg::PBR_SLOT_SECOND  : pbr_pkg::PBR_SLOT_THIRD;

  ////////////////////////////////////////////////////////////////////////////////
  // Counters and polled addresses

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      poll_count_o <= '0;
    end else if (poll_hit) begin
      poll_count_o <= poll_count_o + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      error_count_o <= '0;
    end else if (com_error_i && bus_attach_o) begin
      error_count_o <= error_count_o + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_poll_address_o <= '0;
      polled_slot_mask_o  <= 3'h0;
    end else if (poll_hit) begin
      last_poll_address_o                <= poll_address_i;
      polled_slot_mask_o[hit_slot[1:0]]  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply sequencer

  pbr_pkg::pbr_rsp_t     rsp_q;
  pbr_pkg::pbr_slot_t    slot_q;
  logic [`PBR_ADDR_W-1:0] addr_q;
  logic [`PBR_TICK_W-1:0] tick_q;
  logic [`PBR_DLY_W-1:0]  dly_q;
  logic [`PBR_ITEM_W-1:0] lvl_q;
  logic [`PBR_SEL_W-1:0]  rd_addr;
  logic [`PBR_ITEM_W-1:0] rd_data;
  logic                   tick;

  assign tick = (tick_q == `PBR_TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_q  <= pbr_pkg::PBR_RSP_IDLE;
      slot_q <= pbr_pkg::PBR_SLOT_PRIMARY;
      addr_q <= '0;
    end else if (!bus_attach_o) begin
      rsp_q <= pbr_pkg::PBR_RSP_IDLE;
    end else begin
      case (rsp_q)
        pbr_pkg::PBR_RSP_IDLE: begin
          if (poll_hit) begin
            rsp_q  <= pbr_pkg::PBR_RSP_WAIT;
            slot_q <= hit_slot;
            addr_q <= poll_address_i;
          end
        end
        pbr_pkg::PBR_RSP_WAIT: begin
          if (dly_q == '0) begin
            rsp_q <= pbr_pkg::PBR_RSP_RDL;
          end
        end
        pbr_pkg::PBR_RSP_RDL: begin
          rsp_q <= pbr_pkg::PBR_RSP_RDT;
        end
        pbr_pkg::PBR_RSP_RDT: begin
          rsp_q <= pbr_pkg::PBR_RSP_SEND;
        end
        default: begin
          rsp_q <= pbr_pkg::PBR_RSP_IDLE;
        end
      endcase
    end
  end

  // Delay counts whole microseconds from the end of the poll
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_q <= '0;
      dly_q  <= '0;
    end else if (rsp_q == pbr_pkg::PBR_RSP_IDLE) begin
      tick_q <= '0;
      dly_q  <= resp_delay_i;
    end else if (rsp_q == pbr_pkg::PBR_RSP_WAIT && dly_q != '0) begin
      tick_q <= tick ? '0 : tick_q + 1'b1;
      if (tick) begin
        dly_q <= dly_q - 1'b1;
      end
    end
  end

  assign rd_addr = (rsp_q == pbr_pkg::PBR_RSP_RDT) ?
    pick_sel(slot_q, `PBR_PRI_TMP_ITEM, second_temp_selector_i, third_temp_selector_i) :
    pick_sel(slot_q, `PBR_PRI_LVL_ITEM, second_level_selector_i, third_level_selector_i);

  pbr_item_mem #(
    .W     (`PBR_ITEM_W),
    .DEPTH (DEPTH),
    .AW    (`PBR_SEL_W)
  ) u_items (
    .clk_i     (clk_i),
    .wr_en_i   (item_wr_i),
    .wr_addr_i (item_wr_addr_i),
    .wr_data_i (item_wr_data_i),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lvl_q <= '0;
    end else if (rsp_q == pbr_pkg::PBR_RSP_RDT) begin
      lvl_q <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply fields, clamped to their transmitted ranges

  logic [`PBR_ITEM_W-1:0] lvl_clamp;
  logic [`PBR_ITEM_W-1:0] tmp_clamp;

  always_comb begin
    if (lvl_q[`PBR_ITEM_W-1]) begin
      lvl_clamp = '0;
    end else if (lvl_q > `PBR_LVL_MAX) begin
      lvl_clamp = `PBR_LVL_MAX;
    end else begin
      lvl_clamp = lvl_q;
    end
  end

  always_comb begin
    if ($signed(rd_data) > $signed(`PBR_TMP_MAX)) begin
      tmp_clamp = `PBR_TMP_MAX;
    end else if ($signed(rd_data) < -$signed(`PBR_TMP_MAX)) begin
      tmp_clamp = -`PBR_TMP_MAX;
    end else begin
      tmp_clamp = rd_data;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_valid_o <= 1'b0;
    end else begin
      reply_valid_o <= (rsp_q == pbr_pkg::PBR_RSP_SEND) && bus_attach_o;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_address_o <= '0;
      reply_slot_o    <= pbr_pkg::PBR_SLOT_PRIMARY;
      reply_level_o   <= '0;
      reply_temp_o    <= '0;
    end else if (rsp_q == pbr_pkg::PBR_RSP_SEND) begin
      reply_address_o <= addr_q;
      reply_slot_o    <= slot_q;
      reply_level_o   <= lvl_clamp[`PBR_LVL_W-1:0];
      reply_temp_o    <= tmp_clamp[`PBR_TMP_W-1:0];
    end
  end

endmodule

//--- pbr_responder_sva.sv
`include "pbr_map.svh"

module pbr_responder_sva (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  // Command and self-check
  input wire logic                   cmd_valid_i,
  input wire pbr_pkg::pbr_cmd_t      cmd_code_i,
  input wire logic                   xcvr_test_start_o,
  input wire logic                   xcvr_test_done_i,
  input wire logic                   xcvr_test_pass_i,
  // Bus state
  input wire logic                   bus_attach_o,
  input wire logic                   relay_close_o,
  input wire logic                   bus_link_state_o,
  input wire logic                   test_busy_o,
  // Polls and replies
  input wire logic [`PBR_ADDR_W-1:0] primary_address_i,
  input wire logic [`PBR_DLY_W-1:0]  resp_delay_i,
  input wire logic                   poll_end_i,
  input wire logic [`PBR_ADDR_W-1:0] poll_address_i,
  input wire logic                   com_error_i,
  input wire logic                   reply_valid_o,
  input wire logic [`PBR_CNT_W-1:0]  poll_count_o,
  input wire logic [`PBR_CNT_W-1:0]  error_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  a_relay_tracks: assert property (
    relay_close_o == (bus_link_state_o && !test_busy_o) && bus_attach_o == relay_close_o)
    else $error("relay, attach and state disagree");
  a_isolate_cmd: assert property (
    cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_ISOLATE && bus_attach_o && !test_busy_o
    |=> !bus_attach_o && !bus_link_state_o)
    else $error("isolate not taken");
  a_connect_cmd: assert property (
    cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_CONNECT && !bus_attach_o && !test_busy_o
    |=> bus_attach_o && bus_link_state_o)
    else $error("connect not taken");
  a_test_order: assert property (
    cmd_valid_i && cmd_code_i == pbr_pkg::PBR_CMD_TEST && !test_busy_o
    |=> !bus_attach_o && test_busy_o ##1 xcvr_test_start_o)
    else $error("test did not detach then start");
  a_test_pass: assert property (
    test_busy_o && xcvr_test_done_i && xcvr_test_pass_i
    |=> bus_attach_o && bus_link_state_o && !test_busy_o)
    else $error("passed test did not reconnect");
  a_test_fail: assert property (
    test_busy_o && xcvr_test_done_i && !xcvr_test_pass_i
    |=> !bus_attach_o && !bus_link_state_o && !test_busy_o)
    else $error("failed test did not isolate");
  a_poll_counted: assert property (
    poll_end_i && bus_attach_o && poll_address_i == primary_address_i
    |=> poll_count_o == $past(poll_count_o) + 16'h0001)
    else $error("poll count did not step");
  a_error_counted: assert property (
    com_error_i && bus_attach_o |=> error_count_o == $past(error_count_o) + 16'h0001)
    else $error("error count did not step");
  a_reply_latency: assert property (
    reply_valid_o && resp_delay_i == 16'h0000 |-> $past(poll_end_i, 5))
    else $error("reply not five cycles after poll");
  a_reply_pulse: assert property (
    reply_valid_o |=> !reply_valid_o)
    else $error("reply valid longer than one cycle");
endmodule

//--- pbr_host_model.sv
`include "pbr_map.svh"

module pbr_host_model (
  // Clock
  input  wire logic              clk_i,
  // Poll side
  output logic                   poll_end_o,
  output logic [`PBR_ADDR_W-1:0] poll_address_o,
  output logic                   com_error_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    poll_end_o = 1'b0;
    poll_address_o = 10'h3FF;
    com_error_o = 1'b0;
  end

  // Address lines show the inverse once a poll is over
  task automatic poll(input logic [`PBR_ADDR_W-1:0] a);
    @(negedge clk_i);
    poll_end_o = 1'b1;
    poll_address_o = a;
    @(negedge clk_i);
    poll_end_o = 1'b0;
    poll_address_o = ~a;
  endtask

  task automatic bad_frame();
    @(negedge clk_i);
    com_error_o = 1'b1;
    @(negedge clk_i);
    com_error_o = 1'b0;
  endtask
endmodule

//--- tb_pbr_responder.sv
`include "pbr_map.svh"

module tb_pbr_responder;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_i = 1'b0;
  logic                   resetn_i = 1'b0;
  logic                   cmd_valid_i = 1'b0;
  pbr_pkg::pbr_cmd_t      cmd_code_i = pbr_pkg::PBR_CMD_ISOLATE;
  logic                   xcvr_test_start_o;
  logic                   xcvr_test_done_i = 1'b0;
  logic                   xcvr_test_pass_i = 1'b0;
  logic                   bus_attach_o;
  logic                   relay_close_o;
  logic                   bus_link_state_o;
  logic                   test_busy_o;
  logic [`PBR_ADDR_W-1:0] primary_address_i = 10'h00A;
  logic [`PBR_ADDR_W-1:0] second_station_address_i = 10'h3E7;
  logic [`PBR_ADDR_W-1:0] third_station_address_i = 10'h001;
  logic [`PBR_SEL_W-1:0]  second_level_selector_i = 4'h2;
  logic [`PBR_SEL_W-1:0]  second_temp_selector_i = 4'h3;
  logic [`PBR_SEL_W-1:0]  third_level_selector_i = 4'h4;
  logic [`PBR_SEL_W-1:0]  third_temp_selector_i = 4'h5;
  logic [`PBR_DLY_W-1:0]  resp_delay_i = 16'h0000;
  logic                   item_wr_i = 1'b0;
  logic [`PBR_SEL_W-1:0]  item_wr_addr_i = 4'h0;
  logic [`PBR_ITEM_W-1:0] item_wr_data_i = 20'h00000;
  logic                   poll_end_i;
  logic [`PBR_ADDR_W-1:0] poll_address_i;
  logic                   com_error_i;
  logic                   reply_valid_o;
  logic [`PBR_ADDR_W-1:0] reply_address_o;
  pbr_pkg::pbr_slot_t     reply_slot_o;
  logic [`PBR_LVL_W-1:0]  reply_level_o;
  logic [`PBR_TMP_W-1:0]  reply_temp_o;
  logic [`PBR_CNT_W-1:0]  poll_count_o;
  logic [`PBR_CNT_W-1:0]  error_count_o;
  logic [`PBR_ADDR_W-1:0] last_poll_address_o;
  logic [2:0]             polled_slot_mask_o;
  logic [19:0]            items [6] = '{20'h03039, 20'hFFF06, 20'h15F90, 20'hFDCD8,
                                        20'hFFFFB, 20'h01F3F};
  int                     error_cnt = 0;
  int                     checked = 0;
  int                     cyc = 0;

  pbr_responder u_dut (.*);
  pbr_host_model u_host (.clk_i, .poll_end_o(poll_end_i), .poll_address_o(poll_address_i),
                         .com_error_o(com_error_i));

  always #2 clk_i = ~clk_i;

  // Transceiver answers its self-check three cycles after start
  always @(posedge clk_i) begin
    if (xcvr_test_start_o === 1'b1) begin
      repeat (3) @(negedge clk_i);
      xcvr_test_done_i = 1'b1;
      @(negedge clk_i);
      xcvr_test_done_i = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmd(input pbr_pkg::pbr_cmd_t c);
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_code_i = c;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask

  task automatic t_poll(input logic [9:0] a, input logic hit, input logic [1:0] slot,
                        input logic [16:0] lvl, input logic [13:0] tmp);
    int n;
    int lat;
    logic seen;
    lat = 5 + int'(resp_delay_i) * 250;
    n = 1;
    seen = 1'b0;
    u_host.poll(a);
    while (!seen && n < lat + 8) begin
      if (reply_valid_o === 1'b1) begin
        seen = 1'b1;
      end else begin
        @(negedge clk_i);
        n++;
      end
    end
    check(seen, hit);
    if (hit) begin
      check(n, lat);
      check(reply_address_o, a);
      check(reply_slot_o, slot);
      check(reply_level_o, lvl);
      check(reply_temp_o, tmp);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_slots();
    t_poll(10'h00A, 1'b1, 2'h0, 17'h03039, 14'h3F06);
    t_poll(10'h3E7, 1'b1, 2'h1, 17'h13880, 14'h20C1);
    t_poll(10'h001, 1'b1, 2'h2, 17'h00000, 14'h1F3F);
    check(poll_count_o, 32'h3);
    check(polled_slot_mask_o, 32'h7);
    check(last_poll_address_o, 32'h001);
    t_poll(10'h005, 1'b0, 2'h0, 17'h0, 14'h0);
    check(poll_count_o, 32'h3);
  endtask

  task automatic t_disable();
    @(negedge clk_i);
    second_station_address_i = 10'h000;
    third_station_address_i = 10'h3E8;
    t_poll(10'h000, 1'b0, 2'h0, 17'h0, 14'h0);
    t_poll(10'h3E8, 1'b0, 2'h0, 17'h0, 14'h0);
    resp_delay_i = 16'h0001;
    t_poll(10'h00A, 1'b1, 2'h0, 17'h03039, 14'h3F06);
    check(poll_count_o, 32'h4);
  endtask

  task automatic t_iso();
    cmd(pbr_pkg::PBR_CMD_ISOLATE);
    check(bus_attach_o, 32'h0);
    check(relay_close_o, 32'h0);
    cmd(pbr_pkg::PBR_CMD_ISOLATE);
    check(bus_link_state_o, 32'h0);
    t_poll(10'h00A, 1'b0, 2'h0, 17'h0, 14'h0);
    cmd(pbr_pkg::PBR_CMD_CONNECT);
    check(bus_attach_o, 32'h1);
    check(relay_close_o, 32'h1);
    check(bus_link_state_o, 32'h1);
  endtask

  // A detach while a reply waits drops that reply
  task automatic t_abort();
    int n;
    u_host.poll(10'h00A);
    cmd(pbr_pkg::PBR_CMD_ISOLATE);
    cmd(pbr_pkg::PBR_CMD_CONNECT);
    n = 0;
    while (reply_valid_o !== 1'b1 && n < 270) begin
      @(negedge clk_i);
      n++;
    end
    check(n, 270);
    check(poll_count_o, 32'h5);
    check(bus_link_state_o, 32'h1);
  endtask

  task automatic t_btest(input logic pass);
    int n;
    xcvr_test_pass_i = pass;
    cmd(pbr_pkg::PBR_CMD_TEST);
    check(bus_attach_o, 32'h0);
    check(test_busy_o, 32'h1);
    n = 0;
    while (test_busy_o !== 1'b0 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check(test_busy_o, 32'h0);
    check(bus_attach_o, {31'h0, pass});
    check(relay_close_o, {31'h0, pass});
    check(bus_link_state_o, {31'h0, pass});
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    check(bus_attach_o, 32'h1);
    check(relay_close_o, 32'h1);
    check(bus_link_state_o, 32'h1);
    check(poll_count_o, 32'h0);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_i);
      item_wr_i = 1'b1;
      item_wr_addr_i = i[3:0];
      item_wr_data_i = items[i];
    end
    @(negedge clk_i);
    item_wr_i = 1'b0;
    t_slots();
    t_disable();
    u_host.bad_frame();
    check(error_count_o, 32'h1);
    t_iso();
    t_abort();
    t_btest(1'b1);
    t_btest(1'b0);
    t_btest(1'b1);
    cmd(pbr_pkg::PBR_CMD_CONNECT);
    check(bus_attach_o, 32'h1);
    end_of_test();
  end
endmodule

bind pbr_responder pbr_responder_sva u_sva (
  .clk_i             (clk_i),
  .resetn_i          (resetn_i),
  .cmd_valid_i       (cmd_valid_i),
  .cmd_code_i        (cmd_code_i),
  .xcvr_test_start_o (xcvr_test_start_o),
  .xcvr_test_done_i  (xcvr_test_done_i),
  .xcvr_test_pass_i  (xcvr_test_pass_i),
  .bus_attach_o      (bus_attach_o),
  .relay_close_o     (relay_close_o),
  .bus_link_state_o  (bus_link_state_o),
  .test_busy_o       (test_busy_o),
  .primary_address_i (primary_address_i),
  .resp_delay_i      (resp_delay_i),
  .poll_end_i        (poll_end_i),
  .poll_address_i    (poll_address_i),
  .com_error_i       (com_error_i),
  .reply_valid_o     (reply_valid_o),
  .poll_count_o      (poll_count_o),
  .error_count_o     (error_count_o)
);
